// ==== design/ipv_pkg.sv ====
// Constants, field layouts and carrier types of the interrupt priority and vectoring block.
//
// Functional notes
// - Vector address is the vector base plus a byte offset; each slot is four bytes.
// - External interrupt two: number 21, offset 0054h, own control register.
// - Timer A interrupt: number 22, offset 0058h.
// - Timer B interrupt: number 24, offset 0060h.
// - External interrupt one: number 25, offset 0064h.
// - External interrupt three: number 26, offset 0068h.
// - External interrupt zero: number 29, offset 0074h.
// - Sensor unit interrupt: number 42, offset 00A8h.
// - First voltage monitor interrupt: number 50, offset 00C8h.
// - Second voltage monitor interrupt: number 51, offset 00CCh.
// - Software numbers 32 to 41 and 56 to 63 ignore the global enable.
// - A voltage monitor uses its maskable vector only when its select bit is 1.
// - Bits b2 to b0 hold level 0 to 7; level 0 disables the source.
// - Bit b3 shows a pending request; software may only clear it.
// - Flash ready and timer C request flags are read-only to software.
// - Bits b4 to b7 are unassigned; software writes zero there.
// - Each control register decodes at its own byte address.
// - A request sets the flag; acknowledge and vector branch clear it.
// - Acknowledge needs enable, flag and level above processor level; level 7 masks all.
// - A cleared global enable suppresses every maskable request.
package ipv_pkg;

  localparam int NSRC = 14;

  // Source order: flash ready, timer C, key, serial tx, serial rx, ext two,
  // timer A, timer B, ext one, ext three, ext zero, sensor, monitor 1, monitor 2.
  localparam logic [7:0] CTRL_ADDR [NSRC] = '{
    8'h41, 8'h47, 8'h4D, 8'h51, 8'h52, 8'h55, 8'h56,
    8'h58, 8'h59, 8'h5A, 8'h5D, 8'h6A, 8'h72, 8'h73};
  localparam logic [5:0] SRC_NUM [NSRC] = '{
    6'h01, 6'h07, 6'h0D, 6'h11, 6'h12, 6'h15, 6'h16,
    6'h18, 6'h19, 6'h1A, 6'h1D, 6'h2A, 6'h32, 6'h33};
  localparam logic [7:0] VEC_OFS [NSRC] = '{
    8'h04, 8'h1C, 8'h34, 8'h44, 8'h48, 8'h54, 8'h58,
    8'h60, 8'h64, 8'h68, 8'h74, 8'hA8, 8'hC8, 8'hCC};
  localparam logic [NSRC-1:0] FLAG_RO = 14'h0003;
  localparam int IDX_VM1 = 12;
  localparam int IDX_VM2 = 13;

  // Control register fields.
  localparam int LVL_LSB = 0;
  localparam int LVL_MSB = 2;
  localparam int IR_BIT = 3;
  localparam logic [2:0] LVL_RESET = 3'h0;
  localparam logic [2:0] LVL_OFF = 3'h0;
  localparam logic IR_RESET = 1'b0;

  // Vector base and configuration registers.
  localparam int VBASE_W = 20;
  localparam logic [VBASE_W-1:0] VBASE_RESET = 20'h0_0000;
  localparam logic [7:0] ADDR_VBASE0 = 8'h80;
  localparam logic [7:0] ADDR_VBASE1 = 8'h81;
  localparam logic [7:0] ADDR_VBASE2 = 8'h82;
  localparam logic [7:0] ADDR_CFG = 8'h84;
  localparam logic [7:0] ADDR_STAT = 8'h85;
  localparam int GIE_BIT = 0;
  localparam int PPL_LSB = 1;
  localparam int PPL_MSB = 3;
  localparam int VM1SEL_BIT = 4;
  localparam int VM2SEL_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [2:0] PPL_ALL_MASKED = 3'h7;

  // Software interrupt numbers that bypass the global enable.
  localparam logic [5:0] SW_A_LO = 6'h20;
  localparam logic [5:0] SW_A_HI = 6'h29;
  localparam logic [5:0] SW_B_LO = 6'h38;
  localparam logic [5:0] SW_B_HI = 6'h3F;

  typedef struct packed {
    logic ir;
    logic [2:0] lvl;
  } ipv_ctrl_t;

  typedef struct packed {
    logic valid;
    logic [5:0] num;
    logic [2:0] lvl;
    logic [VBASE_W-1:0] addr;
  } ipv_req_t;

endpackage

// ==== design/ipv_top.sv ====
// Interrupt control registers, priority arbitration and relocatable vector addressing.
`timescale 1ns/1ns
module ipv_top (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [ipv_pkg::NSRC-1:0] src_event,
  input wire logic cpu_ack,
  input wire logic [5:0] cpu_ack_num,
  input wire logic sw_int_req,
  input wire logic [5:0] sw_int_num,
  output ipv_pkg::ipv_req_t irq_out,
  output logic sw_vec_valid,
  output logic [ipv_pkg::VBASE_W-1:0] sw_vec_addr
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [ipv_pkg::VBASE_W-1:0] vec_addr(
    input logic [ipv_pkg::VBASE_W-1:0] base,
    input logic [7:0] ofs
  );
    vec_addr = base + {12'h000, ofs};
  endfunction

  function automatic logic is_sw_num(input logic [5:0] num);
    is_sw_num = (num >= ipv_pkg::SW_A_LO && num <= ipv_pkg::SW_A_HI) ||
                (num >= ipv_pkg::SW_B_LO && num <= ipv_pkg::SW_B_HI);
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  ipv_pkg::ipv_ctrl_t ctrl_reg [ipv_pkg::NSRC];
  logic [ipv_pkg::VBASE_W-1:0] vbase_reg;
  logic [7:0] cfg_reg;
  logic gie;
  logic [2:0] ppl;
  logic [ipv_pkg::NSRC-1:0] elig;
  logic found;
  logic [3:0] best_idx;
  logic [2:0] best_lvl;

  assign gie = cfg_reg[ipv_pkg::GIE_BIT];
  assign ppl = cfg_reg[ipv_pkg::PPL_MSB:ipv_pkg::PPL_LSB];

  // Request flags and priority levels, one register per source.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < ipv_pkg::NSRC; i++) begin
        ctrl_reg[i].ir <= ipv_pkg::IR_RESET;
        ctrl_reg[i].lvl <= ipv_pkg::LVL_RESET;
      end
    end else begin
      for (int i = 0; i < ipv_pkg::NSRC; i++) begin
        if (reg_wr && reg_addr == ipv_pkg::CTRL_ADDR[i]) begin
          ctrl_reg[i].lvl <= reg_wdata[ipv_pkg::LVL_MSB:ipv_pkg::LVL_LSB];
        end
        if (src_event[i]) begin
          ctrl_reg[i].ir <= 1'b1;
        end else if (cpu_ack && cpu_ack_num == ipv_pkg::SRC_NUM[i]) begin
          ctrl_reg[i].ir <= 1'b0;
        end else if (reg_wr && reg_addr == ipv_pkg::CTRL_ADDR[i] &&
                     !reg_wdata[ipv_pkg::IR_BIT] && !ipv_pkg::FLAG_RO[i]) begin
          ctrl_reg[i].ir <= 1'b0;
        end
      end
    end
  end

  // Vector base, written one byte lane at a time.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      vbase_reg <= ipv_pkg::VBASE_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ipv_pkg::ADDR_VBASE0: begin
          vbase_reg[7:0] <= reg_wdata;
        end
        ipv_pkg::ADDR_VBASE1: begin
          vbase_reg[15:8] <= reg_wdata;
        end
        ipv_pkg::ADDR_VBASE2: begin
          vbase_reg[19:16] <= reg_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Global enable, processor level and monitor select bits.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= ipv_pkg::CFG_RESET;
    end else if (reg_wr && reg_addr == ipv_pkg::ADDR_CFG) begin
      cfg_reg <= {2'b00, reg_wdata[5:0]};
    end
  end

  // Read data stand in the cycle after the strobe; unassigned bits read zero.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= 8'h00;
      for (int i = 0; i < ipv_pkg::NSRC; i++) begin
        if (reg_addr == ipv_pkg::CTRL_ADDR[i]) begin
          reg_rdata <= {4'h0, ctrl_reg[i].ir, ctrl_reg[i].lvl};
        end
      end
      case (reg_addr)
        ipv_pkg::ADDR_VBASE0: begin
          reg_rdata <= vbase_reg[7:0];
        end
        ipv_pkg::ADDR_VBASE1: begin
          reg_rdata <= vbase_reg[15:8];
        end
        ipv_pkg::ADDR_VBASE2: begin
          reg_rdata <= {4'h0, vbase_reg[19:16]};
        end
        ipv_pkg::ADDR_CFG: begin
          reg_rdata <= cfg_reg;
        end
        ipv_pkg::ADDR_STAT: begin
          reg_rdata <= {irq_out.valid, 1'b0, irq_out.num};
        end
        default: begin
        end
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // Arbitration
  // ****************************************
  always_comb begin
    for (int i = 0; i < ipv_pkg::NSRC; i++) begin
      elig[i] = gie && ctrl_reg[i].ir && (ctrl_reg[i].lvl > ppl);
    end
    elig[ipv_pkg::IDX_VM1] = elig[ipv_pkg::IDX_VM1] && cfg_reg[ipv_pkg::VM1SEL_BIT];
    elig[ipv_pkg::IDX_VM2] = elig[ipv_pkg::IDX_VM2] && cfg_reg[ipv_pkg::VM2SEL_BIT];
  end

  // Highest level wins; on a tie the lower software number wins.
  always_comb begin
    found = 1'b0;
    best_idx = 4'h0;
    best_lvl = ipv_pkg::LVL_OFF;
    for (int i = 0; i < ipv_pkg::NSRC; i++) begin
      if (elig[i] && (!found || ctrl_reg[i].lvl > best_lvl)) begin
        found = 1'b1;
        best_idx = 4'(i);
        best_lvl = ctrl_reg[i].lvl;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_out <= '0;
    end else begin
      irq_out.valid <= found;
      irq_out.num <= ipv_pkg::SRC_NUM[best_idx];
      irq_out.lvl <= best_lvl;
      irq_out.addr <= vec_addr(vbase_reg, ipv_pkg::VEC_OFS[best_idx]);
    end
  end

  // Software interrupts are served whatever the global enable says.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sw_vec_valid <= 1'b0;
      sw_vec_addr <= ipv_pkg::VBASE_RESET;
    end else begin
      sw_vec_valid <= sw_int_req && is_sw_num(sw_int_num);
      sw_vec_addr <= vec_addr(vbase_reg, {sw_int_num, 2'b00});
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  sequence s_ack_timer_a;
    cpu_ack && cpu_ack_num == ipv_pkg::SRC_NUM[6];
  endsequence

  sequence s_write_timer_a_clear;
    reg_wr && reg_addr == ipv_pkg::CTRL_ADDR[6] && !reg_wdata[ipv_pkg::IR_BIT] && !src_event[6];
  endsequence

  sequence s_write_timer_a;
    reg_wr && reg_addr == ipv_pkg::CTRL_ADDR[6];
  endsequence

  sequence s_read_timer_a;
    reg_rd && reg_addr == ipv_pkg::CTRL_ADDR[6];
  endsequence

  a_gie_suppress: assert property (!gie |=> !irq_out.valid)
    else $error("Request presented while global enable was clear.");
  a_level_above_ppl: assert property (irq_out.valid |-> irq_out.lvl > $past(ppl) && $past(ppl) != 3'h7)
    else $error("Presented level not above processor level.");
  a_level_nonzero: assert property (irq_out.valid |-> irq_out.lvl != 3'h0)
    else $error("Level zero source was presented.");
  a_vector_map: assert property (irq_out.valid |-> irq_out.addr == $past(vbase_reg) + {12'h000, irq_out.num, 2'b00})
    else $error("Vector address does not match software number.");
  a_sw_bypass: assert property (sw_int_req && is_sw_num(sw_int_num) && !gie |=> sw_vec_valid)
    else $error("Software interrupt blocked.");
  a_vm_select: assert property (irq_out.valid && irq_out.num == 6'h32 |-> $past(cfg_reg[ipv_pkg::VM1SEL_BIT]))
    else $error("Monitor one presented while not maskable.");
  a_ack_clear: assert property (s_ack_timer_a and !src_event[6] |=> !ctrl_reg[6].ir)
    else $error("Acknowledge did not clear the flag.");
  a_event_set: assert property (src_event[6] |=> ctrl_reg[6].ir)
    else $error("Event did not set the flag.");
  a_ro_flag: assert property (reg_wr && reg_addr == ipv_pkg::CTRL_ADDR[0] && ctrl_reg[0].ir &&
                              !(cpu_ack && cpu_ack_num == ipv_pkg::SRC_NUM[0]) |=> ctrl_reg[0].ir)
    else $error("Read-only flag changed by software.");
  a_ro_flag_c: assert property (reg_wr && reg_addr == ipv_pkg::CTRL_ADDR[1] && ctrl_reg[1].ir &&
                                !(cpu_ack && cpu_ack_num == ipv_pkg::SRC_NUM[1]) |=> ctrl_reg[1].ir)
    else $error("Read-only flag changed by software.");
  a_sw_clear: assert property (s_write_timer_a_clear and !(cpu_ack && cpu_ack_num == ipv_pkg::SRC_NUM[6]) |=> !ctrl_reg[6].ir)
    else $error("Software clear of flag failed.");
  a_no_sw_set: assert property (reg_wr && !ctrl_reg[2].ir && !src_event[2] |=> !ctrl_reg[2].ir)
    else $error("Software write set a request flag.");
  a_read_upper: assert property (s_read_timer_a |=> reg_rdata[7:4] == 4'h0)
    else $error("Unassigned bits read nonzero.");
  a_highest: assert property (irq_out.valid && $past(elig[7]) |-> irq_out.lvl >= $past(ctrl_reg[7].lvl))
    else $error("Presented request is not the highest level.");
  a_level_write: assert property (s_write_timer_a |=> ctrl_reg[6].lvl == $past(reg_wdata[2:0]))
    else $error("Level field not written.");
  a_read_level: assert property (s_read_timer_a |=> reg_rdata[2:0] == $past(ctrl_reg[6].lvl))
    else $error("Control register read back wrong level.");
  a_ppl_masks_all: assert property (ppl == ipv_pkg::PPL_ALL_MASKED |=> !irq_out.valid)
    else $error("Request presented with every level masked.");
  a_vm2_select: assert property (irq_out.valid && irq_out.num == 6'h33 |-> $past(cfg_reg[ipv_pkg::VM2SEL_BIT]))
    else $error("Monitor two presented while not maskable.");
  a_sw_refuse: assert property (sw_int_req && !is_sw_num(sw_int_num) |=> !sw_vec_valid)
    else $error("Software lookup accepted an illegal number.");
  a_sw_addr: assert property (sw_int_req |=> sw_vec_addr == $past(vbase_reg) + {12'h000, $past(sw_int_num), 2'b00})
    else $error("Software vector address wrong.");
  a_flag_hold: assert property (ctrl_reg[6].ir && !cpu_ack && !reg_wr |=> ctrl_reg[6].ir)
    else $error("Request flag dropped with no clear.");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("Read data left standing without a read.");

endmodule

// ==== test/ipv_cpu_model.sv ====
// Behavioural CPU core that acknowledges presented interrupt requests after a delay.
`timescale 1ns/1ns
module ipv_cpu_model #(
  parameter int DELAY = 4
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire ipv_pkg::ipv_req_t irq_out,
  output logic cpu_ack,
  output logic [5:0] cpu_ack_num
);
  int cnt;
  int hold;
  // The request stays visible one cycle after an acknowledge, so a hold-off skips it.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_ack <= 1'b0;
      cpu_ack_num <= 6'h00;
      cnt <= 0;
      hold <= 0;
    end else begin
      cpu_ack <= 1'b0;
      cpu_ack_num <= ~cpu_ack_num;
      if (hold > 0) begin
        hold <= hold - 1;
      end else if (irq_out.valid) begin
        if (cnt == DELAY) begin
          cpu_ack <= 1'b1;
          cpu_ack_num <= irq_out.num;
          cnt <= 0;
          hold <= 3;
        end else begin
          cnt <= cnt + 1;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule

// ==== test/ipv_top_tb.sv ====
// Self-checking testbench of the interrupt priority and vectoring block.
`timescale 1ns/1ns
module ipv_top_tb;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] idx;
    logic [5:0] num;
    logic [7:0] ofs;
  } ipv_row_t;
  localparam logic [19:0] BASE = 20'h1_2340;
  logic sys_clk, reset_n, reg_wr, reg_rd, sw_int_req, cpu_ack, sw_vec_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [13:0] src_event;
  logic [5:0] cpu_ack_num, sw_int_num;
  logic [19:0] sw_vec_addr;
  ipv_pkg::ipv_req_t irq_out;
  int num_errors = 0;
  int total_checks = 0;
  ipv_row_t rows [9] = '{'{8'h55, 4'h5, 6'h15, 8'h54}, '{8'h56, 4'h6, 6'h16, 8'h58}, '{8'h58, 4'h7, 6'h18, 8'h60},
    '{8'h59, 4'h8, 6'h19, 8'h64}, '{8'h5A, 4'h9, 6'h1A, 8'h68}, '{8'h5D, 4'hA, 6'h1D, 8'h74},
    '{8'h6A, 4'hB, 6'h2A, 8'hA8}, '{8'h72, 4'hC, 6'h32, 8'hC8}, '{8'h73, 4'hD, 6'h33, 8'hCC}};
  logic [5:0] sw_nums [7] = '{6'h1F, 6'h20, 6'h29, 6'h2A, 6'h37, 6'h38, 6'h3F};
  logic sw_exp [7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};

  ipv_top ipv_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event), .cpu_ack(cpu_ack),
    .cpu_ack_num(cpu_ack_num), .sw_int_req(sw_int_req), .sw_int_num(sw_int_num), .irq_out(irq_out),
    .sw_vec_valid(sw_vec_valid), .sw_vec_addr(sw_vec_addr));
  ipv_cpu_model ipv_cpu_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .irq_out(irq_out), .cpu_ack(cpu_ack),
    .cpu_ack_num(cpu_ack_num));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(20'(reg_rdata), 20'(e));
  endtask

  task automatic fire(input logic [13:0] m);
    @(posedge sys_clk);
    src_event <= m;
    @(posedge sys_clk);
    src_event <= 14'h0000;
  endtask

  task automatic wait_irq(input logic [5:0] n);
    int k;
    k = 0;
    @(posedge sys_clk);
    #1;
    while (irq_out.valid !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk(20'(irq_out.num), 20'(n));
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
    #1 chk(20'(irq_out.valid), 20'h0_0000);
  endtask

  initial begin
    #(6000 * 100);
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {reg_wr, reg_rd, sw_int_req, reset_n} = 4'h0;
    {reg_addr, reg_wdata, src_event, sw_int_num} = '0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h4D, 8'h00);
    $display("test reset done");
    wr(8'h80, 8'h40);
    wr(8'h81, 8'h23);
    wr(8'h82, 8'h01);
    wr(8'h84, 8'h31);
    foreach (rows[i]) begin
      wr(rows[i].addr, 8'h03);
      fire(14'h0001 << rows[i].idx);
      wait_irq(rows[i].num);
      chk(irq_out.addr, BASE + 20'(rows[i].ofs));
      rd(rows[i].addr, 8'h0B);
      repeat (10) @(posedge sys_clk);
      rd(rows[i].addr, 8'h03);
      idle(1);
      wr(rows[i].addr, 8'h00);
    end
    $display("test vector table done");
    wr(8'h6A, 8'h02);
    wr(8'h58, 8'h05);
    fire(14'h0880);
    wait_irq(6'h18);
    repeat (25) @(posedge sys_clk);
    rd(8'h6A, 8'h02);
    wr(8'h6A, 8'h00);
    wr(8'h58, 8'h00);
    $display("test priority done");
    wr(8'h84, 8'h30);
    wr(8'h56, 8'h03);
    fire(14'h0040);
    idle(5);
    wr(8'h56, 8'h03);
    rd(8'h56, 8'h03);
    wr(8'h56, 8'h0B);
    rd(8'h56, 8'h03);
    wr(8'h84, 8'h37);
    fire(14'h0040);
    idle(5);
    wr(8'h84, 8'h35);
    wait_irq(6'h16);
    repeat (10) @(posedge sys_clk);
    wr(8'h56, 8'h00);
    $display("test masking done");
    wr(8'h84, 8'h01);
    wr(8'h72, 8'h07);
    fire(14'h1000);
    idle(5);
    wr(8'h84, 8'h11);
    wait_irq(6'h32);
    repeat (10) @(posedge sys_clk);
    wr(8'h72, 8'h00);
    fire(14'h0001);
    rd(8'h41, 8'h08);
    wr(8'h41, 8'h00);
    rd(8'h41, 8'h08);
    wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    $display("test flags done");
    wr(8'h84, 8'h00);
    foreach (sw_nums[i]) begin
      @(posedge sys_clk);
      sw_int_req <= 1'b1;
      sw_int_num <= sw_nums[i];
      @(posedge sys_clk);
      sw_int_req <= 1'b0;
      #1 chk(20'(sw_vec_valid), 20'(sw_exp[i]));
      if (sw_vec_valid === 1'b1) chk(sw_vec_addr, BASE + 20'(sw_nums[i]) * 20'h0_0004);
    end
    $display("test software lookup done");
    @(posedge sys_clk);
    reset_n <= 1'b0;
    @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(8'h84, 8'h00);
    rd(8'h80, 8'h00);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
